// ==== rtl/dma_write_consts.svh ====
`ifndef DMA_WRITE_CONSTS_SVH
`define DMA_WRITE_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_DATA 8'h00
`define OFS_FEAT_ERR 8'h04
`define OFS_SECCNT 8'h08
`define OFS_SECNUM 8'h0c
`define OFS_CYLLO 8'h10
`define OFS_CYLHI 8'h14
`define OFS_DEVHEAD 8'h18
`define OFS_CMD_STAT 8'h1c
`define OFS_DEVCTL 8'h20
// ****************************************
// Opcodes
// ****************************************
`define OPC_DMA28 8'hca
`define OPC_DMA28_MASK 8'hfe
`define OPC_FUA_EXT 8'h3d
// ****************************************
// Field positions
// ****************************************
`define DH_LBA_BIT 6
`define DH_DEV_BIT 4
`define DC_HOB_BIT 7
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_SEEK 4
`define ST_DRQ 3
`define ST_CORR 2
`define ST_INDEX 1
`define ST_ERR 0
`define ER_CRC 7
`define ER_IDNF 4
`define ER_ABRT 2
// ****************************************
// Counts and reset values
// ****************************************
`define SECTORS_256 17'h00100
`define SECTORS_65536 17'h10000
`define DEVHEAD_RST 8'ha0
`define REG8_RST 8'h00
`endif

// ==== rtl/dma_write_pkg.sv ====
package dma_write_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_XFER,
      ST_MEDIA,
      ST_DONE
   } wr_state_t;
endpackage

// ==== rtl/disk_write_dma_command_handler.sv ====
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "dma_write_consts.svh"
module disk_write_dma_command_handler
   import dma_write_pkg::*;
#(
   parameter int WORDS_PER_SECTOR = 256,
   parameter int SECTORS_PER_TRACK = 63,
   parameter int HEADS = 16,
   parameter logic [47:0] MAX_LBA = 48'h0000_ffff_ffff,
   parameter logic DEV_NUM = 1'b0
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Slave DMA channel
   output logic dmarq_o,
   input wire logic dmack_i,
   input wire logic [15:0] dma_data_i,
   input wire logic crc_err_i,
   // Media side
   output logic [15:0] med_word_o,
   output logic med_word_vld_o,
   output logic med_req_o,
   output logic [47:0] med_lba_o,
   output logic med_commit_o,
   input wire logic med_ack_i,
   input wire logic med_unc_i,
   // Host interrupt
   output logic intrq_o
);

   // ****************************************
   // State
   // ****************************************
   wr_state_t state_r;
   logic [31:0] rdata_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [7:0] cnt_cur_r, cnt_prev_r;
   logic [7:0] sn_cur_r, sn_prev_r;
   logic [7:0] cl_cur_r, cl_prev_r;
   logic [7:0] ch_cur_r, ch_prev_r;
   logic [7:0] devhead_r;
   logic [7:0] devctl_r;
   logic [7:0] status_r;
   logic [7:0] error_r;
   logic intrq_r;
   logic ext_r;
   logic lba_mode_r;
   logic crc_seen_r;
   logic unc_seen_r;
   logic [47:0] lba_r;
   logic [7:0] chs_sec_r;
   logic [3:0] chs_head_r;
   logic [15:0] chs_cyl_r;
   logic [16:0] left_r;
   logic [15:0] word_cnt_r;
   logic [15:0] med_word_r;
   logic med_word_vld_r;

   // ****************************************
   // Bus decode
   // ****************************************
   wire addr_phase = hsel_i && htrans_i[1] && hready_i;
   wire rd_take = addr_phase && !hwrite_i;
   wire wr_take = addr_phase && hwrite_i;
   wire [7:0] rd_ofs = haddr_i[7:0];
   wire mapped = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'b00);
   wire high_order_byte_select = devctl_r[`DC_HOB_BIT];
   wire busy = (state_r != ST_IDLE);
   wire wr_go = wr_pend_r && !busy;
   wire [7:0] wbyte = hwdata_i[7:0];
   wire wr_cmd = wr_go && (wr_addr_r == `OFS_CMD_STAT);
   wire dev_match = (devhead_r[`DH_DEV_BIT] == DEV_NUM);
   wire is_dma28 = ((wbyte & `OPC_DMA28_MASK) == `OPC_DMA28);
   wire is_fua = (wbyte == `OPC_FUA_EXT);
   wire start28 = wr_cmd && dev_match && is_dma28;
   wire start_ext = wr_cmd && dev_match && is_fua;
   wire bad_cmd = wr_cmd && dev_match && !is_dma28 && !is_fua;

   // ****************************************
   // Register read mux
   // ****************************************
   wire [7:0] rd_byte =
      (rd_ofs == `OFS_FEAT_ERR) ? error_r :
      (rd_ofs == `OFS_SECCNT) ? (high_order_byte_select ? cnt_prev_r : cnt_cur_r) :
      (rd_ofs == `OFS_SECNUM) ? (high_order_byte_select ? sn_prev_r : sn_cur_r) :
      (rd_ofs == `OFS_CYLLO) ? (high_order_byte_select ? cl_prev_r : cl_cur_r) :
      (rd_ofs == `OFS_CYLHI) ? (high_order_byte_select ? ch_prev_r : ch_cur_r) :
      (rd_ofs == `OFS_DEVHEAD) ? devhead_r :
      (rd_ofs == `OFS_CMD_STAT) ? status_r :
      (rd_ofs == `OFS_DEVCTL) ? devctl_r : 8'h00;
   wire [31:0] rd_val = mapped ? {24'h000000, rd_byte} : 32'h0000_0000;
   wire stat_read = rd_take && mapped && (rd_ofs == `OFS_CMD_STAT);

   // ****************************************
   // Start address and count
   // ****************************************
   wire [16:0] cnt28 = (cnt_cur_r == 8'h00) ? `SECTORS_256 : {9'h000, cnt_cur_r};
   wire [15:0] cnt16 = {cnt_prev_r, cnt_cur_r};
   wire [16:0] cnt_ext = (cnt16 == 16'h0000) ? `SECTORS_65536 : {1'b0, cnt16};
   wire lba_sel = devhead_r[`DH_LBA_BIT];
   wire [47:0] lba28 = {20'h00000, devhead_r[3:0], ch_cur_r, cl_cur_r, sn_cur_r};
   wire [47:0] lba48 = {ch_prev_r, cl_prev_r, sn_prev_r, ch_cur_r, cl_cur_r, sn_cur_r};
   wire [31:0] chs_lin = ((32'({ch_cur_r, cl_cur_r}) * 32'(HEADS) + 32'(devhead_r[3:0]))
      * 32'(SECTORS_PER_TRACK)) + 32'(sn_cur_r) - 32'h0000_0001;
   wire [47:0] start_lba = start_ext ? lba48 : (lba_sel ? lba28 : {16'h0000, chs_lin});
   wire [16:0] start_cnt = start_ext ? cnt_ext : cnt28;
   wire [48:0] end_lba = {1'b0, start_lba} + {32'h0000_0000, start_cnt};
   wire range_bad = (end_lba > ({1'b0, MAX_LBA} + 49'h0_0000_0000_0001)) ||
      (!start_ext && !lba_sel && (sn_cur_r == 8'h00));

   // ****************************************
   // Transfer control
   // ****************************************
   wire word_take = (state_r == ST_XFER) && dmack_i;
   wire last_word = (word_cnt_r == 16'(WORDS_PER_SECTOR - 1));
   wire med_ok = (state_r == ST_MEDIA) && med_ack_i && !med_unc_i;
   wire med_bad = (state_r == ST_MEDIA) && med_ack_i && med_unc_i;
   wire last_sector = (left_r == 17'h00001);
   wire sec_wrap = (chs_sec_r == 8'(SECTORS_PER_TRACK));
   wire head_wrap = (chs_head_r == 4'(HEADS - 1));

   // ****************************************
   // State machine
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if ((start28 || start_ext) && !range_bad) begin
                  state_r <= ST_XFER;
               end else if (start28 || start_ext || bad_cmd) begin
                  state_r <= ST_DONE;
               end
            end
            ST_XFER: begin
               if (word_take && last_word) begin
                  state_r <= ST_MEDIA;
               end
            end
            ST_MEDIA: begin
               if (med_bad || (med_ok && last_sector)) begin
                  state_r <= ST_DONE;
               end else if (med_ok) begin
                  state_r <= ST_XFER;
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Command context and address walk
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ext_r <= 1'b0;
         lba_mode_r <= 1'b0;
         lba_r <= 48'h0000_0000_0000;
         chs_sec_r <= `REG8_RST;
         chs_head_r <= 4'h0;
         chs_cyl_r <= 16'h0000;
         left_r <= 17'h00000;
         word_cnt_r <= 16'h0000;
         crc_seen_r <= 1'b0;
         unc_seen_r <= 1'b0;
      end else begin
         if (start28 || start_ext) begin
            ext_r <= start_ext;
            lba_mode_r <= start_ext || lba_sel;
            lba_r <= start_lba;
            chs_sec_r <= sn_cur_r;
            chs_head_r <= devhead_r[3:0];
            chs_cyl_r <= {ch_cur_r, cl_cur_r};
            left_r <= start_cnt;
            word_cnt_r <= 16'h0000;
            crc_seen_r <= 1'b0;
            unc_seen_r <= 1'b0;
         end
         if (word_take) begin
            word_cnt_r <= last_word ? 16'h0000 : word_cnt_r + 16'h0001;
         end
         if (busy && crc_err_i) begin
            crc_seen_r <= 1'b1;
         end
         if (med_bad) begin
            unc_seen_r <= 1'b1;
         end
         if (med_ok) begin
            left_r <= left_r - 17'h00001;
         end
         if (med_ok && !last_sector) begin
            lba_r <= lba_r + 48'h0000_0000_0001;
            chs_sec_r <= sec_wrap ? 8'h01 : chs_sec_r + 8'h01;
            if (sec_wrap) begin
               chs_head_r <= head_wrap ? 4'h0 : chs_head_r + 4'h1;
               chs_cyl_r <= head_wrap ? chs_cyl_r + 16'h0001 : chs_cyl_r;
            end
         end
      end
   end

   // ****************************************
   // Media word path
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         med_word_r <= 16'h0000;
         med_word_vld_r <= 1'b0;
      end else begin
         med_word_vld_r <= word_take;
         if (word_take) begin
            med_word_r <= dma_data_i;
         end
      end
   end

   // ****************************************
   // Bus pipeline
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= wr_take && mapped;
         if (rd_take) begin
            rdata_r <= rd_val;
         end
         if (wr_take) begin
            wr_addr_r <= rd_ofs;
         end
      end
   end

   // ****************************************
   // Task file registers
   // ****************************************
   wire done = (state_r == ST_DONE);
   wire xfer_ran = !error_r[`ER_ABRT];
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cnt_cur_r <= `REG8_RST;
         cnt_prev_r <= `REG8_RST;
         sn_cur_r <= `REG8_RST;
         sn_prev_r <= `REG8_RST;
         cl_cur_r <= `REG8_RST;
         cl_prev_r <= `REG8_RST;
         ch_cur_r <= `REG8_RST;
         ch_prev_r <= `REG8_RST;
         devhead_r <= `DEVHEAD_RST;
         devctl_r <= `REG8_RST;
      end else if (done && xfer_ran) begin
         cnt_cur_r <= left_r[7:0];
         cnt_prev_r <= left_r[15:8];
         if (ext_r) begin
            sn_cur_r <= lba_r[7:0];
            cl_cur_r <= lba_r[15:8];
            ch_cur_r <= lba_r[23:16];
            sn_prev_r <= lba_r[31:24];
            cl_prev_r <= lba_r[39:32];
            ch_prev_r <= lba_r[47:40];
         end else if (lba_mode_r) begin
            sn_cur_r <= lba_r[7:0];
            cl_cur_r <= lba_r[15:8];
            ch_cur_r <= lba_r[23:16];
            devhead_r[3:0] <= lba_r[27:24];
         end else begin
            sn_cur_r <= chs_sec_r;
            cl_cur_r <= chs_cyl_r[7:0];
            ch_cur_r <= chs_cyl_r[15:8];
            devhead_r[3:0] <= chs_head_r;
         end
      end else if (wr_pend_r) begin
         if (wr_addr_r == `OFS_DEVCTL) begin
            devctl_r <= wbyte;
         end
         if (wr_go) begin
            case (wr_addr_r)
               `OFS_SECCNT: begin
                  cnt_prev_r <= cnt_cur_r;
                  cnt_cur_r <= wbyte;
               end
               `OFS_SECNUM: begin
                  sn_prev_r <= sn_cur_r;
                  sn_cur_r <= wbyte;
               end
               `OFS_CYLLO: begin
                  cl_prev_r <= cl_cur_r;
                  cl_cur_r <= wbyte;
               end
               `OFS_CYLHI: begin
                  ch_prev_r <= ch_cur_r;
                  ch_cur_r <= wbyte;
               end
               `OFS_DEVHEAD: devhead_r <= wbyte;
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************
   // Status, error and interrupt
   // ****************************************
   wire fail_idn = range_bad && (start28 || start_ext);
   wire any_err = crc_seen_r || unc_seen_r || (error_r != 8'h00);
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         status_r <= 8'h50;
         error_r <= `REG8_RST;
         intrq_r <= 1'b0;
      end else begin
         if (wr_cmd) begin
            error_r <= 8'h00;
            error_r[`ER_IDNF] <= fail_idn;
            error_r[`ER_ABRT] <= bad_cmd;
         end else if (done) begin
            error_r[`ER_CRC] <= crc_seen_r;
            error_r[`ER_ABRT] <= error_r[`ER_ABRT] || unc_seen_r || crc_seen_r;
         end
         status_r[`ST_BUSY] <= busy && !done;
         status_r[`ST_READY] <= 1'b1;
         status_r[`ST_FAULT] <= 1'b0;
         status_r[`ST_SEEK] <= 1'b1;
         status_r[`ST_DRQ] <= (state_r == ST_XFER);
         status_r[`ST_CORR] <= 1'b0;
         status_r[`ST_INDEX] <= 1'b0;
         if (wr_cmd && dev_match) begin
            status_r[`ST_ERR] <= 1'b0;
         end else if (done) begin
            status_r[`ST_ERR] <= any_err;
         end
         if (done) begin
            intrq_r <= 1'b1;
         end else if (stat_read || wr_cmd) begin
            intrq_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign hrdata_o = rdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign dmarq_o = (state_r == ST_XFER);
   assign med_word_o = med_word_r;
   assign med_word_vld_o = med_word_vld_r;
   assign med_req_o = (state_r == ST_MEDIA);
   assign med_lba_o = lba_r;
   assign med_commit_o = ext_r;
   assign intrq_o = intrq_r;
endmodule

// ==== sim/disk_write_dma_command_handler_properties.sv ====
`timescale 1ns/10ps
`include "dma_write_consts.svh"
// ****
// Port checks
// ****
module dwdch_props #(
   parameter int WORDS_PER_SECTOR = 256
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   // Transfer, media and interrupt
   input wire logic dmarq_o,
   input wire logic dmack_i,
   input wire logic [15:0] dma_data_i,
   input wire logic [15:0] med_word_o,
   input wire logic med_word_vld_o,
   input wire logic med_req_o,
   input wire logic med_commit_o,
   input wire logic med_ack_i,
   input wire logic med_unc_i,
   input wire logic intrq_o
);
   logic cmd_ap_r;
   logic fua_r;
   int wcnt_r;
   wire take = dmarq_o && dmack_i;
   wire unc_ack = med_req_o && med_ack_i && med_unc_i;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cmd_ap_r <= 1'b0;
         fua_r <= 1'b0;
         wcnt_r <= 0;
      end else begin
         if (hready_i)
            cmd_ap_r <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == `OFS_CMD_STAT;
         if (cmd_ap_r && hready_i)
            fua_r <= hwdata_i[7:0] == `OPC_FUA_EXT;
         wcnt_r <= med_req_o ? 0 : wcnt_r + int'(take);
      end
   end
   a_word_capture: assert property (take |=> med_word_vld_o && med_word_o == $past(dma_data_i))
      else $error("word not captured");
   a_word_qualified: assert property (!take |=> !med_word_vld_o)
      else $error("word without request");
   a_sector_words: assert property ($rose(med_req_o) |-> wcnt_r == WORDS_PER_SECTOR)
      else $error("wrong words per sector");
   a_unc_stops: assert property (unc_ack |=> (!dmarq_o && !med_req_o) [*8])
      else $error("write went on after error");
   a_intr_after_end: assert property (med_req_o && med_ack_i |-> ##[1:3] (intrq_o || dmarq_o))
      else $error("no interrupt at end");
   a_no_intr_busy: assert property (dmarq_o || med_req_o |-> !intrq_o)
      else $error("interrupt while busy");
   a_fua_commit: assert property (med_req_o |-> med_commit_o == fua_r)
      else $error("commit flag wrong");
   a_req_holds: assert property (med_req_o && !med_ack_i |=> med_req_o && !intrq_o)
      else $error("media request dropped");
   c_unc: cover property (unc_ack);
   c_intr: cover property ($rose(intrq_o));
   c_fua: cover property (med_req_o && med_commit_o);
endmodule
bind disk_write_dma_command_handler dwdch_props #(.WORDS_PER_SECTOR(WORDS_PER_SECTOR)) u_props (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .dmarq_o(dmarq_o), .dmack_i(dmack_i), .dma_data_i(dma_data_i), .med_word_o(med_word_o),
   .med_word_vld_o(med_word_vld_o), .med_req_o(med_req_o), .med_commit_o(med_commit_o),
   .med_ack_i(med_ack_i), .med_unc_i(med_unc_i), .intrq_o(intrq_o)
);

// ==== sim/host_dma_model.sv ====
`timescale 1ns/10ps
// ****
// Host slave transfer channel
// ****
module host_dma_model (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Device side
   input wire logic dmarq_i,
   output logic dmack_o,
   output logic [15:0] dma_data_o,
   // Bench side
   input wire logic stall_i,
   input wire logic [15:0] rnd_i,
   output int words_o,
   output int sum_o
);
   wire go = dmarq_i && !stall_i;
   // Armed from reset, before any opcode
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         dmack_o <= 1'b0;
         dma_data_o <= 16'h0000;
         words_o <= 0;
         sum_o <= 0;
      end else begin
         if (dmack_o && dmarq_i) begin
            words_o <= words_o + 1;
            sum_o <= sum_o + int'(dma_data_o);
         end
         dmack_o <= go && (!dmack_o || dmarq_i);
         dma_data_o <= go && (!dmack_o || dmarq_i) ? rnd_i : ~dma_data_o;
      end
   end
endmodule

// ==== sim/disk_write_dma_command_handler_tb.sv ====
`timescale 1ns/10ps
`include "dma_write_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module disk_write_dma_command_handler_tb;
   localparam int W = 4;
   localparam int HEADS_N = 16, SPT_N = 63;
   logic sys_clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, med_ack_i = 0, med_unc_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, seed = 32'h9e0b945e, rs;
   logic [1:0] htrans_i = 0;
   logic hreadyout_o, hresp_o, dmarq_o, dmack_i, med_word_vld_o, med_req_o, med_commit_o, intrq_o;
   logic [15:0] dma_data_i, med_word_o, rnd = 0;
   logic [47:0] med_lba_o, lba_q[$];
   logic stall = 0, intr_d = 0, crc_on = 0, chs_on = 0, crc_err_i = 0;
   int error_cnt = 0, n_checks = 0, intr_n = 0, sec_idx = 0, unc_at = 0, wsum = 0, words, sum;
   disk_write_dma_command_handler #(.WORDS_PER_SECTOR(W)) uut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .dmarq_o(dmarq_o), .dmack_i(dmack_i), .dma_data_i(dma_data_i), .crc_err_i(crc_err_i),
      .med_word_o(med_word_o), .med_word_vld_o(med_word_vld_o), .med_req_o(med_req_o),
      .med_lba_o(med_lba_o), .med_commit_o(med_commit_o), .med_ack_i(med_ack_i),
      .med_unc_i(med_unc_i), .intrq_o(intrq_o));
   host_dma_model host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .dmarq_i(dmarq_o),
      .dmack_o(dmack_i), .dma_data_o(dma_data_i), .stall_i(stall), .rnd_i(rnd),
      .words_o(words), .sum_o(sum));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   always #12.5 sys_clk_i = ~sys_clk_i;
   // ****
   // Media side and monitors
   // ****
   always @(posedge sys_clk_i) begin
      if (med_word_vld_o === 1'b1) wsum += int'(med_word_o);
      if (intrq_o === 1'b1 && !intr_d) intr_n++;
      intr_d = intrq_o === 1'b1;
      rs = xs();
      stall <= rs[0];
      rnd <= rs[31:16];
      med_ack_i <= 1'b0;
      med_unc_i <= 1'b0;
      crc_err_i <= crc_on && med_req_o === 1'b1 && rs[5:4] == 2'b00;
      if (med_req_o === 1'b1 && !med_ack_i && rs[3:2] == 2'b00) begin
         med_ack_i <= 1'b1;
         med_unc_i <= sec_idx == unc_at;
         lba_q.push_back(med_lba_o);
         sec_idx++;
      end
   end
   task complete_run();
      $display("Checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int k;
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      for (k = 0; k < 9; k++) begin @(posedge sys_clk_i); if (hreadyout_o === 1'b1) break; end
      if (k == 9) begin error_cnt++; complete_run(); end
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= {24'h0, d};
      for (k = 0; k < 9; k++) begin @(posedge sys_clk_i); if (hreadyout_o === 1'b1) break; end
      q = hrdata_o;
      if (k == 9) begin error_cnt++; complete_run(); end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK(nm, {24'h0, e}, q)
   endtask
   // ****
   // One write command and its results
   // ****
   task run(input logic [7:0] op, input int cnt, input logic [47:0] lba, input int ua);
      int n, nw, k, w0, s0, i0;
      logic ext, bad;
      logic [47:0] ea, lin;
      logic [31:0] q;
      ext = op == `OPC_FUA_EXT;
      n = cnt != 0 ? cnt : (ext ? 65536 : 256);
      bad = ua < n;
      nw = bad ? ua + 1 : n;
      lin = 48'((int'(lba[23:8]) * HEADS_N + int'(lba[27:24])) * SPT_N + int'(lba[7:0]) - 1);
      wr(`OFS_SECCNT, cnt[15:8]);
      wr(`OFS_SECCNT, cnt[7:0]);
      for (k = 0; k < 3; k++) begin
         wr(8'(`OFS_SECNUM + 4 * k), lba[24 + 8 * k +: 8]);
         wr(8'(`OFS_SECNUM + 4 * k), lba[8 * k +: 8]);
      end
      wr(`OFS_DEVHEAD, ext ? 8'h40 : {chs_on ? 4'ha : 4'he, lba[27:24]});
      lba_q.delete();
      sec_idx = 0;
      unc_at = ua;
      w0 = words;
      s0 = sum;
      i0 = intr_n;
      wsum = 0;
      wr(`OFS_CMD_STAT, op);
      for (k = 0; k < n * 60 + 99 && intrq_o !== 1'b1; k++) @(posedge sys_clk_i);
      if (intrq_o !== 1'b1) begin error_cnt++; complete_run(); end
      `CHK("sectors", nw, lba_q.size())
      foreach (lba_q[i]) `CHK("lba", (chs_on ? lin : lba) + 48'(i), lba_q[i])
      `CHK("words", nw * W, words - w0)
      `CHK("data", sum - s0, wsum)
      rd("status", `OFS_CMD_STAT, (bad || crc_on) ? 8'h51 : 8'h50);
      `CHK("intr", 1, intr_n - i0)
      `CHK("intrq", 1'b0, intrq_o)
      rd("error", `OFS_FEAT_ERR, {crc_on, 4'h0, bad || crc_on, 2'h0});
      ea = lba + 48'(nw - 1);
      if (!ext) rd("count", `OFS_SECCNT, 8'(n - (bad ? ua : n)));
      for (k = 0; k <= int'(ext); k++) begin
         wr(`OFS_DEVCTL, {k[0], 7'h0});
         rd("addr0", `OFS_SECNUM, ea[24 * k +: 8]);
         rd("addr1", `OFS_CYLLO, ea[24 * k + 8 +: 8]);
         rd("addr2", `OFS_CYLHI, ea[24 * k + 16 +: 8]);
      end
      wr(`OFS_DEVCTL, 8'h00);
      bus(1'b0, `OFS_DEVHEAD, 8'h00, q);
      if (!ext) `CHK("head", ea[27:24], q[3:0])
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      rd("status", `OFS_CMD_STAT, 8'h50);
      rd("error", `OFS_FEAT_ERR, 8'h00);
      rd("devhead", `OFS_DEVHEAD, 8'ha0);
      run(8'hca, 2, 48'h0123456, 999);
      crc_on = 1'b1;
      run(8'hcb, 0, 48'h0fffe80, 999);
      crc_on = 1'b0;
      chs_on = 1'b1;
      run(8'hca, 3, 48'h0000_0301_0205, 999);
      chs_on = 1'b0;
      run(8'hca, 3, 48'h0000010, 1);
      run(8'h3d, 3, 48'h0000_8a12_34fe, 2);
      run(8'h3d, 258, 48'h0000_0000_1000, 999);
      complete_run();
   end
   initial begin
      #2500000;
      error_cnt++;
      complete_run();
   end
endmodule
